// [verilog/ea_mode_decode_stack_select.sv]
// Behaviour
// - modes 000/001 are data/address register direct
// - modes 010/011/100 are indirect, postincrement, predecrement
// - modes 101/110 are displacement and index forms
// - special mode register field 000,001,100 absolute/immediate
// - special mode 010/011 are program counter relative
// - classes imply program counter, pointers, status word
// - only listed instructions route EA to status/flags
// - register seven always means the active stack pointer
// - privilege bit picks supervisor or user pointer
// - supervisor state hides user pointer from address operands
// - user state hides supervisor pointer from operands and implicit references, not from the bus port
// - stack grows down, predecrement push, postincrement pop
// - mode bits 5:3, register bits 2:0 of opword
// - byte steps through stack pointer move by two
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ea_decode_map.svh"

module ea_mode_decode_stack_select (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic eaStepPulse,
    output logic [3:0] eaModeOut,
    output logic [2:0] eaRegOut,
    output logic eaInvalidOut,
    output logic statusRouteOut,
    output logic flagsRouteOut,
    output logic [4:0] implicitRefOut,
    output logic accessFaultOut,
    output logic [31:0] activePtrOut,
    output logic [31:0] stackAddrOut
);

    // ------------------------------------------------------------
    // Software visible state
    // ------------------------------------------------------------
    logic [15:0] opwordR; // Operation word under decode
    logic superBitR; // Privilege state bit of the status word
    ea_decode_pkg::op_size_t sizeR; // Operand size of the instruction
    ea_decode_pkg::insn_class_t classR; // Instruction class
    logic [31:0] superPtrR; // Supervisor stack pointer
    logic [31:0] userPtrR; // User stack pointer
    logic ackR; // Wishbone acknowledge
    logic [31:0] datOR; // Read data

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic busReq; // New request not yet acknowledged
    logic busWr; // Write being taken this cycle
    logic busRd; // Read being taken this cycle
    logic [31:0] laneMask; // Byte enables widened to bits

    assign busReq = wb_cyc_i && wb_stb_i && !ackR;
    assign busWr = busReq && wb_we_i;
    assign busRd = busReq && !wb_we_i;
    assign laneMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // ------------------------------------------------------------
    // Field decode and stack arithmetic
    // ------------------------------------------------------------
    ea_decode_pkg::ea_mode_t decMode; // Decoded addressing mode
    logic [2:0] decReg; // Register subfield
    logic decStackStep; // Stepping mode through register seven
    logic [31:0] activePtr; // Pointer the privilege bit selects
    logic stepDec; // Step direction, high for decrement
    logic [31:0] stepNext; // Pointer after the step
    logic [31:0] stepAddr; // Address used by the access
    logic cmdPush; // Push command written this cycle
    logic cmdPop; // Pop command written this cycle
    logic eaStepTake; // Sequencer step that moves the stack pointer
    logic stepAny; // Any pointer step this cycle

    ea_field_decode fieldDec (
        .eaField(opwordR[`EA_MODE_MSB:`EA_REG_LSB]),
        .mode(decMode),
        .regNum(decReg),
        .stackStep(decStackStep)
    );

    // Active pointer follows the privilege bit
    assign activePtr = superBitR ? superPtrR : userPtrR;

    assign cmdPush = busWr && (wb_adr_i == `EA_OFS_STACK_CMD) && wb_sel_i[0]
        && wb_dat_i[`EA_CMD_PUSH_BIT];
    assign cmdPop = busWr && (wb_adr_i == `EA_OFS_STACK_CMD) && wb_sel_i[0]
        && wb_dat_i[`EA_CMD_POP_BIT] && !wb_dat_i[`EA_CMD_PUSH_BIT];
    assign eaStepTake = eaStepPulse && decStackStep;
    assign stepAny = cmdPush || cmdPop || eaStepTake;

    // Push and predecrement go down; pop and postincrement go up
    always_comb
    begin
        if (cmdPush || cmdPop)
        begin
            stepDec = cmdPush;
        end
        else
        begin
            stepDec = (decMode == ea_decode_pkg::EA_ADDR_PREDEC);
        end
    end

    stack_adjust stackStep (
        .curPtr(activePtr),
        .decrement(stepDec),
        .size(sizeR),
        .stackReg(1'b1),
        .nextPtr(stepNext),
        .accessAddr(stepAddr)
    );

    // ------------------------------------------------------------
    // Routing, implicit references and protection
    // ------------------------------------------------------------
    logic flagsRoute; // EA field reaches the condition flags byte
    logic statusRoute; // EA field reaches the whole status word
    logic [4:0] implicitRef; // Implicit references of the class
    logic accessFault; // Protected pointer asked for

    // Only the listed instruction classes may reach status or flags
    always_comb
    begin
        flagsRoute = 1'b0;
        statusRoute = 1'b0;
        unique case (classR)
            ea_decode_pkg::CLS_AND_IMM_FLAGS,
            ea_decode_pkg::CLS_XOR_IMM_FLAGS,
            ea_decode_pkg::CLS_OR_IMM_FLAGS,
            ea_decode_pkg::CLS_MOVE_TO_FLAGS: flagsRoute = 1'b1;
            ea_decode_pkg::CLS_AND_IMM_STATUS,
            ea_decode_pkg::CLS_XOR_IMM_STATUS,
            ea_decode_pkg::CLS_OR_IMM_STATUS,
            ea_decode_pkg::CLS_MOVE_TO_STATUS,
            ea_decode_pkg::CLS_MOVE_FROM_STATUS: statusRoute = 1'b1;
            default:
            begin
                // Every other class leaves the EA field on ordinary operands
                flagsRoute = 1'b0;
                statusRoute = 1'b0;
            end
        endcase
    end

    // Implicit references come from the class, not from the EA field
    always_comb
    begin
        implicitRef = 5'h00;
        accessFault = 1'b0;
        unique case (classR)
            ea_decode_pkg::CLS_STACK_IMPLICIT:
            begin
                implicitRef[`EA_IMPL_ACTIVE] = 1'b1;
            end
            ea_decode_pkg::CLS_PROG_IMPLICIT:
            begin
                implicitRef[`EA_IMPL_PROG] = 1'b1;
            end
            ea_decode_pkg::CLS_USER_PTR_MOVE:
            begin
                // Explicit user pointer move, not address-register addressing
                implicitRef[`EA_IMPL_USER] = 1'b1;
            end
            ea_decode_pkg::CLS_SUPER_IMPLICIT:
            begin
                // User state never sees the supervisor pointer
                implicitRef[`EA_IMPL_SUPER] = superBitR;
                accessFault = !superBitR;
            end
            ea_decode_pkg::CLS_AND_IMM_FLAGS,
            ea_decode_pkg::CLS_AND_IMM_STATUS,
            ea_decode_pkg::CLS_XOR_IMM_FLAGS,
            ea_decode_pkg::CLS_XOR_IMM_STATUS,
            ea_decode_pkg::CLS_OR_IMM_FLAGS,
            ea_decode_pkg::CLS_OR_IMM_STATUS,
            ea_decode_pkg::CLS_MOVE_TO_FLAGS,
            ea_decode_pkg::CLS_MOVE_TO_STATUS,
            ea_decode_pkg::CLS_MOVE_FROM_STATUS:
            begin
                implicitRef[`EA_IMPL_STATUS] = 1'b1;
            end
            default:
            begin
                implicitRef = 5'h00;
                accessFault = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Operation word and control fields, byte lanes honoured
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            opwordR <= `EA_OPWORD_RESET;
            superBitR <= `EA_SUPER_RESET;
            sizeR <= ea_decode_pkg::SZ_BYTE;
            classR <= ea_decode_pkg::CLS_GENERAL;
        end
        else if (busWr && (wb_adr_i == `EA_OFS_OPWORD))
        begin
            opwordR <= (opwordR & ~laneMask[15:0]) | (wb_dat_i[15:0] & laneMask[15:0]);
        end
        else if (busWr && (wb_adr_i == `EA_OFS_CTRL) && wb_sel_i[0])
        begin
            superBitR <= wb_dat_i[`EA_CTRL_SUPER_BIT];
            sizeR <= ea_decode_pkg::op_size_t'(wb_dat_i[`EA_CTRL_SIZE_MSB:`EA_CTRL_SIZE_LSB]);
            classR <= ea_decode_pkg::insn_class_t'(
                wb_dat_i[`EA_CTRL_CLASS_MSB:`EA_CTRL_CLASS_LSB]);
        end
    end

    // ------------------------------------------------------------
    // Stack pointers
    // ------------------------------------------------------------
    // Only the active pointer ever steps; a bus write to a pointer
    // cannot meet a step, since a step needs another register write
    // or the sequencer pulse, and the pulse loses to the bus write
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            superPtrR <= `EA_PTR_RESET;
        end
        else if (busWr && (wb_adr_i == `EA_OFS_SUPER_PTR))
        begin
            superPtrR <= (superPtrR & ~laneMask) | (wb_dat_i & laneMask);
        end
        else if (stepAny && superBitR)
        begin
            superPtrR <= stepNext;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            userPtrR <= `EA_PTR_RESET;
        end
        else if (busWr && (wb_adr_i == `EA_OFS_USER_PTR))
        begin
            userPtrR <= (userPtrR & ~laneMask) | (wb_dat_i & laneMask);
        end
        else if (stepAny && !superBitR)
        begin
            // In supervisor state register seven never reaches this one
            userPtrR <= stepNext;
        end
    end

    // ------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------
    // One wait state: ack rises the cycle after the request, then drops
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ackR <= 1'b0;
        end
        else
        begin
            ackR <= busReq;
        end
    end

    // Read mux; unmapped offsets read as zero and still acknowledge
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            datOR <= `EA_WORD_ZERO;
        end
        else if (busRd)
        begin
            datOR <= `EA_WORD_ZERO;
            unique case (wb_adr_i)
                `EA_OFS_OPWORD: datOR[15:0] <= opwordR;
                `EA_OFS_CTRL:
                begin
                    datOR[`EA_CTRL_SUPER_BIT] <= superBitR;
                    datOR[`EA_CTRL_SIZE_MSB:`EA_CTRL_SIZE_LSB] <= sizeR;
                    datOR[`EA_CTRL_CLASS_MSB:`EA_CTRL_CLASS_LSB] <= classR;
                end
                `EA_OFS_DECODE:
                begin
                    datOR[`EA_DEC_MODE_MSB:`EA_DEC_MODE_LSB] <= decMode;
                    datOR[`EA_DEC_REG_MSB:`EA_DEC_REG_LSB] <= decReg;
                    datOR[`EA_DEC_INVALID_BIT] <= (decMode == ea_decode_pkg::EA_ILLEGAL);
                    datOR[`EA_DEC_STATUS_BIT] <= statusRoute;
                    datOR[`EA_DEC_FLAGS_BIT] <= flagsRoute;
                    datOR[`EA_DEC_IMPL_MSB:`EA_DEC_IMPL_LSB] <= implicitRef;
                    datOR[`EA_DEC_SUPER_BIT] <= superBitR;
                    datOR[`EA_DEC_FAULT_BIT] <= accessFault;
                end
                `EA_OFS_SUPER_PTR: datOR <= superPtrR;
                `EA_OFS_USER_PTR: datOR <= userPtrR;
                `EA_OFS_AREG_VIEW: datOR <= activePtr;
                default: datOR <= `EA_WORD_ZERO;
            endcase
        end
    end

    assign wb_ack_o = ackR;
    assign wb_dat_o = datOR;

    // ------------------------------------------------------------
    // Registered outputs to the sequencer
    // ------------------------------------------------------------
    // Decode results trail the operation word by one cycle
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            eaModeOut <= ea_decode_pkg::EA_DATA_DIRECT;
            eaRegOut <= 3'h0;
            eaInvalidOut <= 1'b0;
        end
        else
        begin
            eaModeOut <= decMode;
            eaRegOut <= decReg;
            eaInvalidOut <= (decMode == ea_decode_pkg::EA_ILLEGAL);
        end
    end

    // Routing and protection flags
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            statusRouteOut <= 1'b0;
            flagsRouteOut <= 1'b0;
            implicitRefOut <= 5'h00;
            accessFaultOut <= 1'b0;
        end
        else
        begin
            statusRouteOut <= statusRoute;
            flagsRouteOut <= flagsRoute;
            implicitRefOut <= implicitRef;
            accessFaultOut <= accessFault;
        end
    end

    // Active pointer mirror and address of the last stack access
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            activePtrOut <= `EA_PTR_RESET;
        end
        else
        begin
            activePtrOut <= activePtr;
        end
    end

    // Holds until the next step
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            stackAddrOut <= `EA_PTR_RESET;
        end
        else if (stepAny)
        begin
            stackAddrOut <= stepAddr;
        end
    end

endmodule : ea_mode_decode_stack_select

`default_nettype wire

// [common/ea_decode_map.svh]
// ----------------------------------------------------------------
// Register map, field positions and constants of the EA decoder
// ----------------------------------------------------------------
`ifndef EA_DECODE_MAP_SVH
`define EA_DECODE_MAP_SVH

// Wishbone word offsets (byte addresses)
`define EA_OFS_OPWORD 8'h00
`define EA_OFS_CTRL 8'h04
`define EA_OFS_DECODE 8'h08
`define EA_OFS_SUPER_PTR 8'h0c
`define EA_OFS_USER_PTR 8'h10
`define EA_OFS_STACK_CMD 8'h14
`define EA_OFS_AREG_VIEW 8'h18

// Effective-address field inside the operation word
`define EA_REG_LSB 0
`define EA_REG_MSB 2
`define EA_MODE_LSB 3
`define EA_MODE_MSB 5

// Mode subfield codes
`define EA_M_DREG 3'h0
`define EA_M_AREG 3'h1
`define EA_M_IND 3'h2
`define EA_M_POSTINC 3'h3
`define EA_M_PREDEC 3'h4
`define EA_M_DISP 3'h5
`define EA_M_INDEX 3'h6
`define EA_M_SPECIAL 3'h7

// Register subfield codes under the special mode
`define EA_S_ABS_SHORT 3'h0
`define EA_S_ABS_LONG 3'h1
`define EA_S_PROG_DISP 3'h2
`define EA_S_PROG_INDEX 3'h3
`define EA_S_IMMEDIATE 3'h4

// Register number that stands for the active stack pointer
`define EA_STACK_REG 3'h7

// Control register fields
`define EA_CTRL_SUPER_BIT 0
`define EA_CTRL_SIZE_LSB 1
`define EA_CTRL_SIZE_MSB 2
`define EA_CTRL_CLASS_LSB 4
`define EA_CTRL_CLASS_MSB 7

// Stack command bits
`define EA_CMD_PUSH_BIT 0
`define EA_CMD_POP_BIT 1

// Decode status fields
`define EA_DEC_MODE_LSB 0
`define EA_DEC_MODE_MSB 3
`define EA_DEC_REG_LSB 4
`define EA_DEC_REG_MSB 6
`define EA_DEC_INVALID_BIT 7
`define EA_DEC_STATUS_BIT 8
`define EA_DEC_FLAGS_BIT 9
`define EA_DEC_IMPL_LSB 10
`define EA_DEC_IMPL_MSB 14
`define EA_DEC_SUPER_BIT 15
`define EA_DEC_FAULT_BIT 16

// Implicit reference vector bit positions
`define EA_IMPL_PROG 0
`define EA_IMPL_ACTIVE 1
`define EA_IMPL_SUPER 2
`define EA_IMPL_USER 3
`define EA_IMPL_STATUS 4

// Reset values
`define EA_OPWORD_RESET 16'h0000
`define EA_SUPER_RESET 1'b1
`define EA_PTR_RESET 32'h00000000
`define EA_WORD_ZERO 32'h00000000

// Pointer step sizes
`define EA_STEP_ONE 32'h00000001
`define EA_STEP_TWO 32'h00000002
`define EA_STEP_FOUR 32'h00000004

`endif

// [common/ea_decode_pkg.sv]
// ----------------------------------------------------------------
// Types shared by the EA decoder files
// ----------------------------------------------------------------
package ea_decode_pkg;

    // Decoded addressing mode
    typedef enum logic [3:0] {
        EA_DATA_DIRECT = 4'h0,
        EA_ADDR_DIRECT = 4'h1,
        EA_ADDR_IND = 4'h2,
        EA_ADDR_POSTINC = 4'h3,
        EA_ADDR_PREDEC = 4'h4,
        EA_ADDR_DISP = 4'h5,
        EA_ADDR_INDEX = 4'h6,
        EA_ABS_SHORT = 4'h7,
        EA_ABS_LONG = 4'h8,
        EA_PROG_DISP = 4'h9,
        EA_PROG_INDEX = 4'ha,
        EA_IMMEDIATE = 4'hb,
        EA_ILLEGAL = 4'hf
    } ea_mode_t;

    // Operand size
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2,
        SZ_RSVD = 2'h3
    } op_size_t;

    // Instruction class given by the sequencer
    typedef enum logic [3:0] {
        CLS_GENERAL = 4'h0,
        CLS_AND_IMM_FLAGS = 4'h1,
        CLS_AND_IMM_STATUS = 4'h2,
        CLS_XOR_IMM_FLAGS = 4'h3,
        CLS_XOR_IMM_STATUS = 4'h4,
        CLS_OR_IMM_FLAGS = 4'h5,
        CLS_OR_IMM_STATUS = 4'h6,
        CLS_MOVE_TO_FLAGS = 4'h7,
        CLS_MOVE_TO_STATUS = 4'h8,
        CLS_MOVE_FROM_STATUS = 4'h9,
        CLS_STACK_IMPLICIT = 4'ha,
        CLS_PROG_IMPLICIT = 4'hb,
        CLS_USER_PTR_MOVE = 4'hc,
        CLS_SUPER_IMPLICIT = 4'hd,
        CLS_RSVD_E = 4'he,
        CLS_RSVD_F = 4'hf
    } insn_class_t;

endpackage : ea_decode_pkg

// [verilog/ea_field_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ea_decode_map.svh"

// ----------------------------------------------------------------
// Six-bit effective-address field to addressing mode
// ----------------------------------------------------------------
module ea_field_decode (
    input wire logic [5:0] eaField,
    output var ea_decode_pkg::ea_mode_t mode,
    output logic [2:0] regNum,
    output logic stackStep
);

    logic [2:0] modeBits; // Mode subfield
    logic [2:0] regBits; // Register subfield

    assign modeBits = eaField[`EA_MODE_MSB:`EA_MODE_LSB];
    assign regBits = eaField[`EA_REG_MSB:`EA_REG_LSB];
    assign regNum = regBits;

    // Mode lookup; the register field only matters under the special mode
    always_comb
    begin
        unique case (modeBits)
            `EA_M_DREG: mode = ea_decode_pkg::EA_DATA_DIRECT;
            `EA_M_AREG: mode = ea_decode_pkg::EA_ADDR_DIRECT;
            `EA_M_IND: mode = ea_decode_pkg::EA_ADDR_IND;
            `EA_M_POSTINC: mode = ea_decode_pkg::EA_ADDR_POSTINC;
            `EA_M_PREDEC: mode = ea_decode_pkg::EA_ADDR_PREDEC;
            `EA_M_DISP: mode = ea_decode_pkg::EA_ADDR_DISP;
            `EA_M_INDEX: mode = ea_decode_pkg::EA_ADDR_INDEX;
            default:
            begin
                // Special mode: register field selects the sub-mode
                unique case (regBits)
                    `EA_S_ABS_SHORT: mode = ea_decode_pkg::EA_ABS_SHORT;
                    `EA_S_ABS_LONG: mode = ea_decode_pkg::EA_ABS_LONG;
                    `EA_S_PROG_DISP: mode = ea_decode_pkg::EA_PROG_DISP;
                    `EA_S_PROG_INDEX: mode = ea_decode_pkg::EA_PROG_INDEX;
                    `EA_S_IMMEDIATE: mode = ea_decode_pkg::EA_IMMEDIATE;
                    default: mode = ea_decode_pkg::EA_ILLEGAL;
                endcase
            end
        endcase
    end

    // Stepping modes through register seven move the stack pointer
    assign stackStep = ((modeBits == `EA_M_POSTINC) || (modeBits == `EA_M_PREDEC))
        && (regBits == `EA_STACK_REG);

endmodule : ea_field_decode

`default_nettype wire

// [verilog/stack_adjust.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ea_decode_map.svh"

// ----------------------------------------------------------------
// Stack pointer step: decrement before use, increment after use
// ----------------------------------------------------------------
module stack_adjust (
    input wire logic [31:0] curPtr,
    input wire logic decrement,
    input wire ea_decode_pkg::op_size_t size,
    input wire logic stackReg,
    output logic [31:0] nextPtr,
    output logic [31:0] accessAddr
);

    logic [31:0] step; // Bytes to move by

    // Byte steps through the stack pointer use two, keeping it word aligned
    always_comb
    begin
        unique case (size)
            ea_decode_pkg::SZ_BYTE: step = stackReg ? `EA_STEP_TWO : `EA_STEP_ONE;
            ea_decode_pkg::SZ_WORD: step = `EA_STEP_TWO;
            ea_decode_pkg::SZ_LONG: step = `EA_STEP_FOUR;
            ea_decode_pkg::SZ_RSVD: step = `EA_STEP_FOUR;
        endcase
    end

    // Stack grows downward: push uses the new value, pop the old one
    assign nextPtr = decrement ? (curPtr - step) : (curPtr + step);
    assign accessAddr = decrement ? nextPtr : curPtr;

endmodule : stack_adjust

`default_nettype wire

// [testbench/step_seq_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Sequencer side: one step pulse per request
// ----------------------------------------
module step_seq_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic fire,
    output logic eaStepPulse
);
    // Pulse lasts one cycle; a held fire repeats it every other cycle
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            eaStepPulse <= 1'b0;
        else
            eaStepPulse <= fire && !eaStepPulse;
    end
endmodule : step_seq_model
`default_nettype wire

// [testbench/ea_decode_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module ea_decode_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic eaStepPulse,
    input wire logic [3:0] eaModeOut,
    input wire logic [2:0] eaRegOut,
    input wire logic eaInvalidOut,
    input wire logic statusRouteOut,
    input wire logic flagsRouteOut,
    input wire logic [31:0] activePtrOut,
    input wire logic [31:0] stackAddrOut
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Bus, decode and step checks
    // ----------------------------------------
    sequence busReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // No bus write and no step: the pointers must not move
    sequence quietBus;
        !eaStepPulse && !(wb_cyc_i && wb_stb_i && wb_we_i);
    endsequence
    a_ack_on_req: assert property (busReq |=> wb_ack_o) else $error("ack missing");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_no_spur_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_invalid_code: assert property (eaInvalidOut == (eaModeOut == 4'hf))
        else $error("invalid flag mismatch");
    a_mode_legal: assert property (eaModeOut <= 4'hb || eaModeOut == 4'hf)
        else $error("mode code out of range");
    a_route_once: assert property (!(statusRouteOut && flagsRouteOut))
        else $error("both routes active");
    a_ptr_hold: assert property (quietBus ##1 quietBus |=> $stable(activePtrOut))
        else $error("pointer moved");
    a_push_down: assert property (eaStepPulse && eaModeOut == 4'h4 && eaRegOut == 3'h7
        && !(wb_cyc_i && wb_stb_i && wb_we_i)
        |=> ##1 stackAddrOut == activePtrOut && activePtrOut < $past(activePtrOut))
        else $error("push not below old pointer");
endmodule : ea_decode_asserts
bind ea_mode_decode_stack_select ea_decode_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
    .eaStepPulse(eaStepPulse), .eaModeOut(eaModeOut), .eaRegOut(eaRegOut),
    .eaInvalidOut(eaInvalidOut), .statusRouteOut(statusRouteOut),
    .flagsRouteOut(flagsRouteOut), .activePtrOut(activePtrOut), .stackAddrOut(stackAddrOut));
`default_nettype wire

// [testbench/tb_ea_mode_decode_stack_select.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_ea_mode_decode_stack_select;
    logic core_clk, rst_n, cyc, stb, we, fire, eaStepPulse, ack, inv, stRt, flRt, fault;
    logic [7:0] adr;
    logic [3:0] sel, mode;
    logic [2:0] regN;
    logic [4:0] impl;
    logic [31:0] dat, q, wbDat, actPtr, stkAddr;
    int nFail, checksDone, cycCnt;
    // Expected mode per register code under the special mode
    logic [3:0] specRow [8] = '{4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hf, 4'hf, 4'hf};
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    ea_mode_decode_stack_select dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wbDat), .wb_ack_o(ack), .eaStepPulse(eaStepPulse), .eaModeOut(mode),
        .eaRegOut(regN), .eaInvalidOut(inv), .statusRouteOut(stRt), .flagsRouteOut(flRt),
        .implicitRefOut(impl), .accessFaultOut(fault), .activePtrOut(actPtr),
        .stackAddrOut(stkAddr));
    step_seq_model u_seq (.core_clk(core_clk), .rst_n(rst_n), .fire(fire),
        .eaStepPulse(eaStepPulse));
    task report_and_stop;
        if (nFail == 0 && checksDone > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            nFail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One classic cycle; waits for ack under a bound
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int t;
        t = 0;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge core_clk) t++; while (ack !== 1'b1 && t < 20);
        if (t >= 20)
            nFail++;
        r = wbDat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task step;
        @(posedge core_clk) fire <= 1'b1;
        @(posedge core_clk) fire <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : step
    // Hang guard
    always @(posedge core_clk)
    begin
        cycCnt++;
        if (cycCnt > 20000)
        begin
            nFail++;
            report_and_stop;
        end
    end
    initial
    begin
        {rst_n, cyc, stb, we, fire, adr, dat} = '0;
        sel = 4'hf;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        bus(1'b0, 8'h04, 32'h0, q);
        chk(q, 32'h1);
        chk(actPtr, 32'h0);
        // Every field value: mode, register, invalid flag
        for (int i = 0; i < 64; i++)
        begin
            bus(1'b1, 8'h00, i, q);
            @(negedge core_clk);
            chk({mode, regN, inv}, {(i[5:3] == 3'h7) ? specRow[i[2:0]] : {1'b0, i[5:3]},
                i[2:0], (i[5:3] == 3'h7 && i[2:0] > 3'h4)});
        end
        for (int c = 0; c < 16; c++)
        begin
            bus(1'b1, 8'h04, (c << 4) | 1, q);
            @(negedge core_clk);
            chk({stRt, flRt, impl}, {c inside {2, 4, 6, 8, 9}, c inside {1, 3, 5, 7},
                c inside {[1:9]}, c == 12, c == 13, c == 10, c == 11});
        end
        bus(1'b1, 8'h04, 32'hd0, q);
        @(negedge core_clk);
        chk(fault, 1'b1);
        bus(1'b1, 8'h04, 32'hc1, q);
        @(negedge core_clk);
        chk({fault, impl[3]}, 2'h1);
        bus(1'b1, 8'h0c, 32'h100, q);
        bus(1'b1, 8'h10, 32'h200, q);
        bus(1'b0, 8'h18, 32'h0, q);
        chk(q, 32'h100);
        bus(1'b1, 8'h04, 32'h0, q);
        bus(1'b0, 8'h18, 32'h0, q);
        chk(q, 32'h200);
        bus(1'b1, 8'h04, 32'h5, q);
        bus(1'b1, 8'h14, 32'h1, q);
        bus(1'b0, 8'h18, 32'h0, q);
        chk({q, stkAddr}, {32'hfc, 32'hfc});
        bus(1'b1, 8'h04, 32'h1, q);
        bus(1'b1, 8'h14, 32'h2, q);
        bus(1'b0, 8'h18, 32'h0, q);
        chk({q, stkAddr}, {32'hfe, 32'hfc});
        bus(1'b1, 8'h00, 32'h27, q);
        step;
        chk({actPtr, stkAddr}, {32'hfc, 32'hfc});
        bus(1'b1, 8'h00, 32'h1f, q);
        step;
        chk({actPtr, stkAddr}, {32'hfe, 32'hfc});
        bus(1'b1, 8'h00, 32'h26, q);
        step;
        chk(actPtr, 32'hfe);
        bus(1'b0, 8'h1c, 32'h0, q);
        chk(q, 32'h0);
        rst_n <= 1'b0;
        @(posedge core_clk) rst_n <= 1'b1;
        @(negedge core_clk) chk({actPtr, stkAddr}, '0);
        report_and_stop;
    end
endmodule : tb_ea_mode_decode_stack_select
`default_nettype wire
